// *** hdl/cmfs_params.svh ***
`ifndef CMFS_PARAMS_SVH
`define CMFS_PARAMS_SVH

// Register byte offsets
`define CMFS_REG_CTRL 8'h00
`define CMFS_REG_FLAGS 8'h04
`define CMFS_REG_MASK 8'h08
`define CMFS_REG_STATUS 8'h0c

// Control register fields
`define CMFS_CTRL_MODE_LSB 0
`define CMFS_CTRL_ADC_EN_BIT 4
`define CMFS_CTRL_ADC_RATE_BIT 5
`define CMFS_CTRL_ADC_DONE_BIT 6

// Charge mode codes
`define CMFS_MODE_OFF 3'h0
`define CMFS_MODE_BYPASS 3'h1
`define CMFS_MODE_DIVIDER 3'h2

// Event flag positions
`define CMFS_EV_ADAPTER_OVP 0
`define CMFS_EV_INPUT_MISSING 1
`define CMFS_EV_INPUT_OVP 2
`define CMFS_EV_INPUT_CURRENT 3
`define CMFS_EV_CELL 4
`define CMFS_EV_CONVERTER 5
`define CMFS_EV_THERMAL_REG 6
`define CMFS_EV_ADC_DONE 7

// Reset values
`define CMFS_MASK_RST 8'h00

// Timing
`define CMFS_CLK_HZ 25000000
`define CMFS_CLK_NS 40
`define CMFS_TICK_US 1000
`define CMFS_TICK_CYCLES ((`CMFS_CLK_HZ / 1000000) * `CMFS_TICK_US)
`define CMFS_ALERT_NS 100000
`define CMFS_ALERT_CYCLES (`CMFS_ALERT_NS / `CMFS_CLK_NS)
`define CMFS_SC_WAIT_MS 650
`define CMFS_REG_TIMEOUT_MS 650
`define CMFS_WINDOW_MS 100000
`define CMFS_UCP_TIMEOUT_MS 100000
`define CMFS_ADP_IN_DEG_MS 10
`define CMFS_ADP_OVP_DEG_MS 1

`endif

// *** hdl/cmfs_pkg.sv ***
package cmfs_pkg;

    typedef enum logic [1:0] {
        CMFS_IDLE = 2'b00,
        CMFS_INIT = 2'b01,
        CMFS_RUN = 2'b10,
        CMFS_SC_WAIT = 2'b11
    } cmfs_chg_t;

    // Comparator outputs of the analog front end
    typedef struct packed {
        logic adapter_present;
        logic adapter_overvoltage;
        logic input_present;
        logic input_below_2v;
        logic input_low_div;
        logic input_low_byp;
        logic reverse_over_4a;
        logic cell_above_2v8;
        logic win_low_ok_div;
        logic win_high_ok_div;
        logic win_low_ok_byp;
        logic win_high_ok_byp;
        logic input_overvoltage;
        logic input_overcurrent;
        logic input_above_ucp_rise;
        logic input_below_ucp_fall;
        logic cell_overvoltage;
        logic cell_overcurrent;
        logic output_short;
        logic flying_cap_short;
        logic switch_overcurrent;
        logic dropout_overvoltage;
        logic regulation_active;
        logic die_overtemp;
        logic adc_all_done;
    } cmfs_sense_t;

    typedef struct packed {
        logic [1:0] htrans;
        logic hsel;
        logic hwrite;
        logic hready;
        logic [2:0] hsize;
        logic [31:0] haddr;
        logic [31:0] hwdata;
    } cmfs_ahb_req_t;

    typedef struct packed {
        cmfs_chg_t chg;
        logic [2:0] mode;
        logic adc_en;
        logic adc_rate;
        logic adc_done;
        logic [7:0] flags;
        logic [7:0] mask;
        logic [14:0] tick_cnt;
        logic tick;
        logic [16:0] run_ms;
        logic ucp_risen;
        logic [9:0] sc_ms;
        logic [9:0] reg_ms;
        logic [7:0] in_deg;
        logic [7:0] ovp_deg;
        logic gate_on;
        logic ovp_trip;
        logic [11:0] alert_cnt;
        logic ahb_wr;
        logic [7:0] ahb_addr;
        logic [31:0] hrdata;
    } cmfs_state_t;

endpackage : cmfs_pkg

// *** hdl/cmfs_top.sv ***
// Operation
// - Any trip stops switching; some drop guard FET
// - Mode codes: off 000, bypass 001, divider 010
// - Input window vs output checked before start
// - Mode changes other than to off ignored while converter runs
// - Monitor converter follows its enable bit, not the charge mode
// - Convert only with input or cell above 2.8V
// - Rate bit picks continuous or single shot
// - Single shot sets done and clears enable in the same cycle
// - Alert pin pulsed low for fixed time
// - Event sets flag; read clears once fault gone
// - No repeat alert for same persisting event
// - Mask suppresses alert, flag still updates
// - Adapter present after deglitch turns gate on
// - Adapter overvoltage: gate off, pulldown, mode off
// - Short watch armed by gate on or input
// - Input below 2V: gate off, mode off, flag
// - Restart startup 650ms after input short
// - Low input or reverse current trips both FETs
// - Window checks gate start, off after 100s
// - Listed protections drop reverse FET, mode off
// - Flying cap and switch checks only in divider
// - Die overtemp watched when charging or converting
// - Enable accepted only with input and cell 2.8V
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cmfs_params.svh"

module cmfs_top #(
    parameter int TICK_CYCLES = `CMFS_TICK_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire cmfs_pkg::cmfs_ahb_req_t ahb_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    input wire cmfs_pkg::cmfs_sense_t sense_i,
    output logic guard_fet_gate_o,
    output logic reverse_block_fet_o,
    output logic input_pulldown_o,
    output logic switching_o,
    output logic adc_convert_o,
    output logic [2:0] charge_mode_field_o,
    input wire logic host_alert_n_i,
    output logic host_alert_n_o,
    output logic host_alert_n_oe_o
);
    import cmfs_pkg::*;

    cmfs_state_t st;
    cmfs_state_t nx;
    cmfs_sense_t s;
    logic charging;
    logic divider;
    logic bypass;
    logic win_en;
    logic win_ok;
    logic armed;
    logic short_fire;
    logic rev_fire;
    logic ovp_fire;
    logic prot_fire;
    logic ucp_timeout;
    logic ucp_fall;
    logic reg_timeout;
    logic die_fire;
    logic conv_fire;
    logic adc_active;
    logic adc_fin;
    logic addr_ph;
    logic rd_flags;
    logic [7:0] ev;
    logic [7:0] cond;
    logic [7:0] fire;
    logic [2:0] wr_mode;
    logic [31:0] rd_mux;

    assign s = sense_i;
    assign divider = (st.mode == `CMFS_MODE_DIVIDER);
    assign bypass = (st.mode == `CMFS_MODE_BYPASS);
    assign charging = (st.chg == CMFS_INIT) || (st.chg == CMFS_RUN);
    assign win_en = (st.run_ms < 17'(`CMFS_WINDOW_MS));
    assign win_ok = divider ? (s.win_low_ok_div && s.win_high_ok_div)
                            : (s.win_low_ok_byp && s.win_high_ok_byp);
    assign armed = st.gate_on || s.input_present;
    assign short_fire = armed && s.input_below_2v && (st.chg != CMFS_SC_WAIT);
    assign rev_fire = (st.chg == CMFS_RUN) && ((divider && s.input_low_div)
                      || (bypass && s.input_low_byp) || s.reverse_over_4a);
    assign ovp_fire = s.adapter_present && s.adapter_overvoltage && !st.ovp_trip
                      && (st.ovp_deg >= 8'(`CMFS_ADP_OVP_DEG_MS));
    assign ucp_timeout = (st.chg == CMFS_RUN) && !st.ucp_risen
                         && (st.run_ms >= 17'(`CMFS_UCP_TIMEOUT_MS));
    assign ucp_fall = (st.chg == CMFS_RUN) && st.ucp_risen && s.input_below_ucp_fall;
    assign reg_timeout = (st.reg_ms >= 10'(`CMFS_REG_TIMEOUT_MS));
    assign die_fire = (charging || st.adc_en) && s.die_overtemp;
    assign conv_fire = charging && divider
                       && (s.flying_cap_short || s.switch_overcurrent);
    assign prot_fire = (charging && (s.input_overvoltage || s.input_overcurrent
                       || ucp_fall || ucp_timeout || s.cell_overvoltage
                       || s.cell_overcurrent || s.output_short
                       || s.dropout_overvoltage || reg_timeout))
                       || conv_fire || die_fire;
    assign adc_active = st.adc_en && (s.input_present || s.cell_above_2v8);
    assign adc_fin = adc_active && s.adc_all_done;
    assign addr_ph = ahb_i.hsel && ahb_i.hready && ahb_i.htrans[1];
    assign rd_flags = addr_ph && !ahb_i.hwrite && (ahb_i.haddr[7:0] == `CMFS_REG_FLAGS);

    // Event pulses and the live conditions behind them
    always_comb begin
        ev = 8'h00;
        ev[`CMFS_EV_ADAPTER_OVP] = ovp_fire;
        ev[`CMFS_EV_INPUT_MISSING] = short_fire || rev_fire;
        ev[`CMFS_EV_INPUT_OVP] = charging && s.input_overvoltage;
        ev[`CMFS_EV_INPUT_CURRENT] = charging && (s.input_overcurrent || ucp_fall
                                     || ucp_timeout);
        ev[`CMFS_EV_CELL] = charging && (s.cell_overvoltage || s.cell_overcurrent);
        ev[`CMFS_EV_CONVERTER] = (charging && s.output_short) || conv_fire;
        ev[`CMFS_EV_THERMAL_REG] = die_fire || (charging && (s.dropout_overvoltage
                                   || reg_timeout));
        ev[`CMFS_EV_ADC_DONE] = adc_fin && st.adc_rate;
        cond = 8'h00;
        cond[`CMFS_EV_ADAPTER_OVP] = s.adapter_overvoltage;
        cond[`CMFS_EV_INPUT_MISSING] = s.input_below_2v || !s.input_present;
        cond[`CMFS_EV_INPUT_OVP] = s.input_overvoltage;
        cond[`CMFS_EV_INPUT_CURRENT] = s.input_overcurrent || s.input_below_ucp_fall;
        cond[`CMFS_EV_CELL] = s.cell_overvoltage || s.cell_overcurrent;
        cond[`CMFS_EV_CONVERTER] = s.output_short || s.flying_cap_short
                                   || s.switch_overcurrent;
        cond[`CMFS_EV_THERMAL_REG] = s.die_overtemp || s.dropout_overvoltage
                                     || s.regulation_active;
        fire = ev & ~st.mask & ~st.flags;
    end

    // Register read mux
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (ahb_i.haddr[7:0])
            `CMFS_REG_CTRL: begin
                rd_mux[2:0] = st.mode;
                rd_mux[`CMFS_CTRL_ADC_EN_BIT] = st.adc_en;
                rd_mux[`CMFS_CTRL_ADC_RATE_BIT] = st.adc_rate;
                rd_mux[`CMFS_CTRL_ADC_DONE_BIT] = st.adc_done;
            end
            `CMFS_REG_FLAGS: rd_mux[7:0] = st.flags;
            `CMFS_REG_MASK: rd_mux[7:0] = st.mask;
            `CMFS_REG_STATUS: begin
                rd_mux[7:0] = {win_en, host_alert_n_i, adc_active, st.ovp_trip,
                               (st.chg == CMFS_RUN), st.gate_on, st.chg};
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Mode code that a host write would store
    always_comb begin
        wr_mode = ahb_i.hwdata[2:0];
        if (wr_mode != `CMFS_MODE_BYPASS && wr_mode != `CMFS_MODE_DIVIDER) begin
            wr_mode = `CMFS_MODE_OFF;
        end
    end

    always_comb begin
        nx = st;
        // Millisecond enable
        nx.tick = 1'b0;
        if (st.tick_cnt == 15'(TICK_CYCLES - 1)) begin
            nx.tick_cnt = 15'h0000;
            nx.tick = 1'b1;
        end else begin
            nx.tick_cnt = st.tick_cnt + 15'h0001;
        end
        // Bus slave: address phase and reads
        nx.ahb_wr = 1'b0;
        if (addr_ph) begin
            nx.ahb_wr = ahb_i.hwrite;
            nx.ahb_addr = ahb_i.haddr[7:0];
            if (!ahb_i.hwrite) begin
                nx.hrdata = rd_mux;
            end
        end
        // Bus slave: write data phase
        if (st.ahb_wr) begin
            unique case (st.ahb_addr)
                `CMFS_REG_CTRL: begin
                    if (wr_mode == `CMFS_MODE_OFF) begin
                        nx.mode = `CMFS_MODE_OFF;
                    end else if (st.chg != CMFS_RUN && st.chg != CMFS_SC_WAIT
                                 && s.input_present && s.cell_above_2v8) begin
                        nx.mode = wr_mode;
                    end
                    nx.adc_en = ahb_i.hwdata[`CMFS_CTRL_ADC_EN_BIT];
                    nx.adc_rate = ahb_i.hwdata[`CMFS_CTRL_ADC_RATE_BIT];
                    if (ahb_i.hwdata[`CMFS_CTRL_ADC_EN_BIT]) begin
                        nx.adc_done = 1'b0;
                    end
                end
                `CMFS_REG_MASK: nx.mask = ahb_i.hwdata[7:0];
                default: nx.mask = st.mask;
            endcase
        end
        // Monitoring converter
        if (adc_fin && st.adc_rate) begin
            nx.adc_done = 1'b1;
            nx.adc_en = 1'b0;
        end
        if (!nx.adc_rate) begin
            nx.adc_done = 1'b0;
        end
        // Guard FET gate sequencing
        if (!s.adapter_present) begin
            nx.gate_on = 1'b0;
            nx.ovp_trip = 1'b0;
            nx.in_deg = 8'h00;
            nx.ovp_deg = 8'h00;
        end else begin
            if (!st.gate_on && !st.ovp_trip && st.chg != CMFS_SC_WAIT) begin
                if (st.in_deg >= 8'(`CMFS_ADP_IN_DEG_MS)) begin
                    nx.gate_on = 1'b1;
                end else if (st.tick) begin
                    nx.in_deg = st.in_deg + 8'h01;
                end
            end
            if (!s.adapter_overvoltage) begin
                nx.ovp_deg = 8'h00;
                nx.ovp_trip = 1'b0;
            end else if (st.tick && st.ovp_deg != 8'hff) begin
                nx.ovp_deg = st.ovp_deg + 8'h01;
            end
        end
        // Charge sequencing
        unique case (st.chg)
            CMFS_IDLE: begin
                if (bypass || divider) begin
                    nx.chg = CMFS_INIT;
                    nx.run_ms = 17'h00000;
                    nx.ucp_risen = 1'b0;
                end
            end
            CMFS_INIT: begin
                if (!(bypass || divider)) begin
                    nx.chg = CMFS_IDLE;
                end else if (!win_en || win_ok) begin
                    nx.chg = CMFS_RUN;
                end
            end
            CMFS_RUN: begin
                if (!(bypass || divider)) begin
                    nx.chg = CMFS_IDLE;
                end
                if (st.tick && st.run_ms != 17'h1ffff) begin
                    nx.run_ms = st.run_ms + 17'h00001;
                end
                if (s.input_above_ucp_rise) begin
                    nx.ucp_risen = 1'b1;
                end
            end
            CMFS_SC_WAIT: begin
                if (st.sc_ms >= 10'(`CMFS_SC_WAIT_MS)) begin
                    nx.chg = CMFS_IDLE;
                end else if (st.tick) begin
                    nx.sc_ms = st.sc_ms + 10'h001;
                end
            end
        endcase
        // Regulation persistence timer
        if (st.chg != CMFS_RUN || !s.regulation_active) begin
            nx.reg_ms = 10'h000;
        end else if (st.tick && !reg_timeout) begin
            nx.reg_ms = st.reg_ms + 10'h001;
        end
        // Protection actions
        if (prot_fire) begin
            nx.mode = `CMFS_MODE_OFF;
            if (charging) begin
                nx.chg = CMFS_IDLE;
            end
        end
        if (ovp_fire) begin
            nx.ovp_trip = 1'b1;
            nx.gate_on = 1'b0;
            nx.in_deg = 8'h00;
            nx.mode = `CMFS_MODE_OFF;
            if (charging) begin
                nx.chg = CMFS_IDLE;
            end
        end
        if (short_fire || rev_fire) begin
            nx.gate_on = 1'b0;
            nx.in_deg = 8'h00;
            nx.mode = `CMFS_MODE_OFF;
            nx.chg = CMFS_SC_WAIT;
            nx.sc_ms = 10'h000;
        end
        // Flags: conditional read clear, set wins
        nx.flags = (st.flags & ~(rd_flags ? ~cond : 8'h00)) | ev;
        // Alert pulse
        if (|fire) begin
            nx.alert_cnt = 12'(`CMFS_ALERT_CYCLES);
        end else if (st.alert_cnt != 12'h000) begin
            nx.alert_cnt = st.alert_cnt - 12'h001;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st <= '0;
            st.chg <= CMFS_IDLE;
            st.mode <= `CMFS_MODE_OFF;
            st.mask <= `CMFS_MASK_RST;
        end else begin
            st <= nx;
        end
    end

    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = st.hrdata;
    assign guard_fet_gate_o = st.gate_on;
    assign reverse_block_fet_o = (st.chg == CMFS_RUN);
    assign switching_o = (st.chg == CMFS_RUN);
    assign input_pulldown_o = st.ovp_trip;
    assign adc_convert_o = adc_active;
    assign charge_mode_field_o = st.mode;
    assign host_alert_n_o = 1'b0;
    assign host_alert_n_oe_o = (st.alert_cnt != 12'h000);

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    property p_mode_legal;
        st.mode inside {`CMFS_MODE_OFF, `CMFS_MODE_BYPASS, `CMFS_MODE_DIVIDER};
    endproperty
    a_mode_legal: assert property (p_mode_legal)
        else $error("Illegal charge mode stored");
    property p_run_lock;
        (st.chg == CMFS_RUN) ##1 (st.mode != `CMFS_MODE_OFF)
            |-> st.mode == $past(st.mode);
    endproperty
    a_run_lock: assert property (p_run_lock)
        else $error("Mode changed while converter running");
    property p_short;
        short_fire |=> !guard_fet_gate_o && (st.mode == `CMFS_MODE_OFF)
            && st.flags[`CMFS_EV_INPUT_MISSING] && !switching_o;
    endproperty
    a_short: assert property (p_short)
        else $error("Input short not handled");
    property p_adapter_ovp;
        ovp_fire |=> input_pulldown_o && !guard_fet_gate_o
            && (st.mode == `CMFS_MODE_OFF) && !reverse_block_fet_o;
    endproperty
    a_adapter_ovp: assert property (p_adapter_ovp)
        else $error("Adapter overvoltage not handled");
    property p_alert_width;
        $rose(host_alert_n_oe_o) |-> host_alert_n_oe_o [*8];
    endproperty
    a_alert_width: assert property (p_alert_width)
        else $error("Alert pulse too short");
    property p_masked;
        (fire == 8'h00) && !host_alert_n_oe_o |=> !host_alert_n_oe_o;
    endproperty
    a_masked: assert property (p_masked)
        else $error("Alert without unmasked new event");
    property p_flag_set;
        (ev != 8'h00) |=> ((st.flags & $past(ev)) == $past(ev));
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("Event flag not set");
    property p_single_shot;
        adc_fin && st.adc_rate |=> st.adc_done && !st.adc_en;
    endproperty
    a_single_shot: assert property (p_single_shot)
        else $error("Single shot completion wrong");
    property p_convert_gate;
        adc_convert_o |-> st.adc_en && (s.input_present || s.cell_above_2v8);
    endproperty
    a_convert_gate: assert property (p_convert_gate)
        else $error("Conversion without supply");
    property p_prot;
        prot_fire |=> (st.mode == `CMFS_MODE_OFF) && !reverse_block_fet_o;
    endproperty
    a_prot: assert property (p_prot)
        else $error("Protection did not clear mode");
    property p_recover;
        $rose(st.chg == CMFS_SC_WAIT) |=> !guard_fet_gate_o [*8];
    endproperty
    a_recover: assert property (p_recover)
        else $error("Gate reopened during short recovery");
    c_run: cover property (st.chg == CMFS_RUN);
    c_short: cover property (short_fire);
    c_single: cover property (st.adc_done);
    c_alert: cover property ($rose(host_alert_n_oe_o));

endmodule : cmfs_top

`default_nettype wire

// *** sim/cmfs_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Host end of the alert line: pull-up, pulse count and width
module cmfs_host_model (
    input wire logic clk_i,
    input wire logic drive_n_i,
    input wire logic oe_i,
    output logic line_o,
    output var int starts_o,
    output var int width_o
);
    int cnt;
    // Released line floats high through the pull-up
    assign line_o = oe_i ? drive_n_i : 1'b1;
    initial begin
        starts_o = 0;
        width_o = 0;
        cnt = 0;
    end
    always @(posedge clk_i) begin
        if (line_o === 1'b0) begin
            if (cnt == 0) begin
                starts_o++;
            end
            cnt++;
        end else if (cnt != 0) begin
            width_o = cnt;
            cnt = 0;
        end
    end
endmodule : cmfs_host_model
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cmfs_params.svh"
module tb_top;
    import cmfs_pkg::*;
    localparam int TICK = 4;
    localparam logic [2:0] WM [8] = '{3'h1, 3'h2, 3'h0, 3'h2, 3'h1, 3'h0, 3'h3, 3'h7};
    localparam logic [2:0] EM [8] = '{3'h1, 3'h1, 3'h0, 3'h2, 3'h2, 3'h0, 3'h0, 3'h0};
    logic core_clk_i, rst_i, rdy, resp, gate, rbf, pdn, sw, adcv, an_o, an_oe, an_line;
    logic [31:0] hrdata, rd;
    logic [2:0] mode;
    logic [1:0] adcb;
    cmfs_ahb_req_t req, ahb_w;
    cmfs_sense_t s;
    int mismatches, checks_done, starts, width, n0;
    always_comb begin
        ahb_w = req;
        ahb_w.hready = rdy;
    end
    cmfs_top #(.TICK_CYCLES(TICK)) cmfs_top_inst (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .ahb_i(ahb_w), .hreadyout_o(rdy),
        .hresp_o(resp), .hrdata_o(hrdata), .sense_i(s), .guard_fet_gate_o(gate),
        .reverse_block_fet_o(rbf), .input_pulldown_o(pdn), .switching_o(sw),
        .adc_convert_o(adcv), .charge_mode_field_o(mode), .host_alert_n_i(an_line),
        .host_alert_n_o(an_o), .host_alert_n_oe_o(an_oe)
    );
    cmfs_host_model cmfs_host_model_inst (
        .clk_i(core_clk_i), .drive_n_i(an_o), .oe_i(an_oe), .line_o(an_line),
        .starts_o(starts), .width_o(width)
    );
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk_i);
    endtask : cyc
    task automatic done_t(input string nm);
        $display("test %s done", nm);
    endtask : done_t
    task automatic wait_rdy;
        int k;
        k = 0;
        @(posedge core_clk_i);
        while (rdy !== 1'b1) begin
            k++;
            if (k > 16) begin
                chk("bus wait", rdy, 1'b1);
                tally_and_finish;
            end
            @(posedge core_clk_i);
        end
    endtask : wait_rdy
    task automatic wait_gate(input logic v, input int lim);
        int k;
        k = 0;
        while (gate !== v) begin
            k++;
            if (k > lim) begin
                chk("gate wait", gate, v);
                tally_and_finish;
            end
            @(posedge core_clk_i);
        end
    endtask : wait_gate
    // One single AHB transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        req.htrans <= 2'b10;
        req.hsel <= 1'b1;
        req.hwrite <= wr;
        req.hsize <= 3'b010;
        req.haddr <= {24'h0, a};
        wait_rdy();
        req.htrans <= 2'b00;
        req.hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : bus
    task automatic wctl(input logic [2:0] m);
        bus(1'b1, `CMFS_REG_CTRL, {26'h0, adcb, 1'b0, m});
    endtask : wctl
    task automatic rdreg(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask : rdreg
    initial begin
        req = '0;
        s = '0;
        adcb = 2'b00;
        mismatches = 0;
        checks_done = 0;
        rst_i = 1'b1;
        cyc(4);
        rst_i <= 1'b0;
        cyc(1);
        chk("rst mode", mode, 3'h0);
        chk("rst resp", resp, 1'b0);
        chk("rst alert", an_oe, 1'b0);
        rdreg(`CMFS_REG_MASK);
        chk("rst mask", rd, 32'h0);
        rdreg(8'h40);
        chk("unmapped", rd, 32'h0);
        done_t("reset");
        s.adapter_present <= 1'b1;
        cyc(20);
        chk("gate early", gate, 1'b0);
        wait_gate(1'b1, 100);
        done_t("gate");
        // Thresholds settled before any enable
        s.input_present <= 1'b1;
        s.win_low_ok_div <= 1'b1;
        s.win_high_ok_div <= 1'b1;
        s.win_low_ok_byp <= 1'b1;
        s.win_high_ok_byp <= 1'b1;
        wctl(3'h1);
        cyc(3);
        chk("no cell", mode, 3'h0);
        s.cell_above_2v8 <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            wctl(WM[i]);
            cyc(3);
            chk("mode", mode, EM[i]);
            chk("switch", sw, EM[i] != 3'h0);
            chk("rbfet", rbf, EM[i] != 3'h0);
        end
        done_t("modes");
        s.flying_cap_short <= 1'b1;
        wctl(3'h1);
        cyc(3);
        chk("fc bypass", sw, 1'b1);
        wctl(3'h0);
        s.flying_cap_short <= 1'b0;
        s.win_low_ok_div <= 1'b0;
        wctl(3'h2);
        cyc(6);
        chk("win hold", sw, 1'b0);
        chk("win mode", mode, 3'h2);
        s.win_low_ok_div <= 1'b1;
        cyc(3);
        chk("win ok", sw, 1'b1);
        s.flying_cap_short <= 1'b1;
        cyc(3);
        chk("fc trip", mode, 3'h0);
        s.flying_cap_short <= 1'b0;
        cyc(2600);
        chk("pulse width", width, `CMFS_ALERT_CYCLES);
        done_t("window");
        rdreg(`CMFS_REG_FLAGS);
        wctl(3'h1);
        cyc(3);
        n0 = starts;
        s.cell_overvoltage <= 1'b1;
        cyc(3);
        chk("ovp mode", mode, 3'h0);
        chk("ovp rbfet", rbf, 1'b0);
        chk("ovp line", an_line, 1'b0);
        rdreg(`CMFS_REG_FLAGS);
        rdreg(`CMFS_REG_FLAGS);
        chk("flag held", rd[4], 1'b1);
        chk("no repeat", starts, n0 + 1);
        s.cell_overvoltage <= 1'b0;
        cyc(2);
        rdreg(`CMFS_REG_FLAGS);
        rdreg(`CMFS_REG_FLAGS);
        chk("flag clear", rd[4], 1'b0);
        cyc(2600);
        bus(1'b1, `CMFS_REG_MASK, 32'h10);
        wctl(3'h1);
        cyc(3);
        n0 = starts;
        s.cell_overvoltage <= 1'b1;
        cyc(6);
        rdreg(`CMFS_REG_FLAGS);
        chk("mask flag", rd[4], 1'b1);
        chk("mask pulse", starts, n0);
        s.cell_overvoltage <= 1'b0;
        bus(1'b1, `CMFS_REG_MASK, 32'h0);
        done_t("flags");
        wctl(3'h1);
        cyc(3);
        s.reverse_over_4a <= 1'b1;
        cyc(3);
        chk("rev mode", mode, 3'h0);
        chk("rev gate", gate, 1'b0);
        chk("rev rbfet", rbf, 1'b0);
        s.reverse_over_4a <= 1'b0;
        rdreg(`CMFS_REG_FLAGS);
        chk("rev flag", rd[1], 1'b1);
        cyc(2000);
        chk("sc wait", gate, 1'b0);
        wait_gate(1'b1, 1500);
        wctl(3'h1);
        cyc(3);
        s.input_below_2v <= 1'b1;
        cyc(3);
        chk("short gate", gate, 1'b0);
        chk("short mode", mode, 3'h0);
        s.input_below_2v <= 1'b0;
        wait_gate(1'b1, 3000);
        done_t("short");
        adcb = 2'b01;
        wctl(3'h0);
        cyc(2);
        chk("adc on", adcv, 1'b1);
        s.input_present <= 1'b0;
        s.cell_above_2v8 <= 1'b0;
        cyc(2);
        chk("adc defer", adcv, 1'b0);
        s.cell_above_2v8 <= 1'b1;
        cyc(2);
        chk("adc cell", adcv, 1'b1);
        s.input_present <= 1'b1;
        rdreg(`CMFS_REG_CTRL);
        chk("cont done", rd[6], 1'b0);
        adcb = 2'b11;
        wctl(3'h0);
        s.adc_all_done <= 1'b1;
        cyc(1);
        s.adc_all_done <= 1'b0;
        cyc(3);
        rdreg(`CMFS_REG_CTRL);
        chk("one shot", rd[6:4], 3'b110);
        adcb = 2'b01;
        done_t("adc");
        wctl(3'h1);
        cyc(3);
        s.adapter_overvoltage <= 1'b1;
        cyc(12);
        chk("aovp gate", gate, 1'b0);
        chk("aovp pdn", pdn, 1'b1);
        chk("aovp mode", mode, 3'h0);
        rdreg(`CMFS_REG_CTRL);
        chk("adc kept", rd[4], 1'b1);
        rdreg(`CMFS_REG_FLAGS);
        chk("aovp flag", rd[0], 1'b1);
        rdreg(`CMFS_REG_STATUS);
        chk("aovp status", rd, 32'h0000_00b0);
        s.die_overtemp <= 1'b1;
        cyc(2);
        rdreg(`CMFS_REG_FLAGS);
        chk("die flag", rd[6], 1'b1);
        chk("die mode", mode, 3'h0);
        done_t("adapter");
        tally_and_finish;
    end
endmodule : tb_top
`default_nettype wire
